// ### verilog/boot_regs.svh
// Purpose: register offsets, fields, reset values and counts of the boot block
// Assumes: word-aligned AHB-Lite map, 32-bit data
// Notes: definitions only
`ifndef BOOT_REGS_SVH
`define BOOT_REGS_SVH

`define CTRL_OFS      8'h00
`define STATUS_OFS    8'h04
`define MADDR_OFS     8'h08
`define MDATA_OFS     8'h0c

`define CTRL_H2C_BIT  0
`define ST_STALL_BIT  0
`define ST_RUN_BIT    1
`define ST_LE_BIT     2
`define ST_LANE_BIT   3
`define ST_MODE_LSB   4
`define ST_WIDTH_LSB  6

`define BOOT_BYTES    1024
`define BOOT_ENTRY    32'h0000_0000
`define ROM_BASE      32'h0000_0000
`define SAMPLE_CYCLES 2'h3

`endif

// ### verilog/boot_pkg.sv
// Purpose: shared types of the boot block
// Assumes: nothing
// Notes: pin codes of mode and width are fixed here
package boot_pkg;
  typedef enum logic [1:0] {
    MODE_HOST = 2'b00,
    MODE_EMU  = 2'b01,
    MODE_ROM  = 2'b10,
    MODE_RSVD = 2'b11
  } boot_mode_t;

  typedef enum logic [1:0] {
    WIDTH_8   = 2'b00,
    WIDTH_16  = 2'b01,
    WIDTH_32  = 2'b10,
    WIDTH_RSV = 2'b11
  } rom_width_t;

  typedef enum logic [2:0] {
    ST_SAMPLE = 3'b000,
    ST_WAIT   = 3'b001,
    ST_REQ    = 3'b010,
    ST_ACK    = 3'b011,
    ST_DRAIN  = 3'b100,
    ST_RUN    = 3'b101
  } state_t;
endpackage

// ### verilog/boot_packer.sv
// Purpose: lane selection and assembly of narrow ROM beats into 32-bit words
// Assumes: one beat per in_valid, same clock as the caller
// Notes: word_valid is a one-cycle pulse
`timescale 1ns/1ps
`include "boot_regs.svh"
module boot_packer
  import boot_pkg::*;
(
  input  wire logic              sys_clk,       // device clock
  input  wire logic              nrst,          // async reset, low
  input  wire boot_pkg::rom_width_t width,      // rom width
  input  wire logic              little_endian_select, // sampled order
  input  wire logic              lane_correction_pin,  // sampled, 1 = default
  input  wire logic              in_valid,      // one beat present
  input  wire logic [31:0]       ext_data_lines,// beat data
  output logic                   word_valid,    // assembled word pulse
  output logic      [31:0]       word           // assembled word
);
  import boot_pkg::*;

  logic [31:0] acc;
  logic [1:0]  cnt;
  logic [31:0] next_acc;
  logic [1:0]  last_cnt;

  // high lanes only in big endian without correction
  wire         big_endian_lane_correction = !little_endian_select && lane_correction_pin;
  wire [7:0]   unit8  = big_endian_lane_correction ?
                        ext_data_lines[31:24] : ext_data_lines[7:0];
  wire [15:0]  unit16 = big_endian_lane_correction ?
                        ext_data_lines[31:16] : ext_data_lines[15:0];

  assign last_cnt = (width == WIDTH_8) ? 2'h3 : (width == WIDTH_16) ? 2'h1 : 2'h0;

  always_comb
  begin
    next_acc = ext_data_lines;
    if (width == WIDTH_8)
      next_acc = little_endian_select ? {unit8, acc[31:8]} : {acc[23:0], unit8};
    else if (width == WIDTH_16)
      next_acc = little_endian_select ? {unit16, acc[31:16]} : {acc[15:0], unit16};
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      acc        <= 32'h0000_0000;
      cnt        <= 2'h0;
      word_valid <= 1'b0;
      word       <= 32'h0000_0000;
    end
    else
    begin
      word_valid <= in_valid && (cnt == last_cnt);
      if (in_valid)
      begin
        acc <= next_acc;
        cnt <= (cnt == last_cnt) ? 2'h0 : cnt + 2'h1;
        if (cnt == last_cnt)
          word <= next_acc;
      end
    end
  end

  chk_word_count: assert property (@(posedge sys_clk) disable iff (!nrst)
    (in_valid && cnt == last_cnt) |=> word_valid)
    else $error("assembled word not emitted");
  chk_lane_pick: assert property (@(posedge sys_clk) disable iff (!nrst)
    (in_valid && width == WIDTH_8 && !lane_correction_pin)
    |-> unit8 == ext_data_lines[7:0])
    else $error("corrected byte not on low lanes");
endmodule

// ### verilog/boot_config.sv
// Purpose: reset-time configuration capture and boot sequencing
// Assumes: AHB-Lite slave with zero wait states; memory and ROM ports on sys_clk
// Notes: config pins are synchronised, sampled just after reset release, then frozen
`timescale 1ns/1ps
`include "boot_regs.svh"
module boot_config
  import boot_pkg::*;
#(
  parameter logic [31:0] ROM_BASE   = `ROM_BASE,
  parameter int          BOOT_BYTES = `BOOT_BYTES
)
(
  input  wire logic        sys_clk,             // 10 MHz clock
  input  wire logic        nrst,                // async reset, low
  input  wire logic        endian_select_pin,   // 1 = little endian
  input  wire logic        lane_correction_pin, // 0 = correction on
  input  wire logic [1:0]  boot_mode_pin,       // boot mode strap
  input  wire logic [1:0]  rom_width_pin,       // ROM width strap
  input  wire logic        hsel,                // AHB select
  input  wire logic [31:0] haddr,               // AHB address
  input  wire logic [1:0]  htrans,              // AHB transfer type
  input  wire logic        hwrite,              // AHB write
  input  wire logic [2:0]  hsize,               // AHB size
  input  wire logic [31:0] hwdata,              // AHB write data
  input  wire logic        hready,              // AHB bus ready
  output logic             hreadyout,           // AHB slave ready
  output logic             hresp,               // AHB response
  output logic      [31:0] hrdata,              // AHB read data
  input  wire logic        core_int_clr,        // core clears h2c bit
  output logic             core_stall,          // core held stalled
  output logic             core_int,            // pending h2c interrupt pulse
  output logic      [31:0] core_start_addr,     // first fetch address
  output logic             periph_rst_n,        // reset of other logic
  output logic             little_endian_select,// sampled byte order
  output logic             lane_correction,     // sampled lane pin
  output logic             rom_req,             // ROM beat request
  output logic      [31:0] rom_addr,            // ROM byte address
  input  wire logic        rom_ack,             // ROM beat done
  input  wire logic [31:0] ext_data_lines,      // ROM data lanes
  output logic             mem_we,              // memory write strobe
  output logic             mem_re,              // memory read strobe
  output logic      [31:0] mem_addr,            // memory address
  output logic      [31:0] mem_wdata,           // memory write data
  input  wire logic [31:0] mem_rdata            // read data, while mem_re high
);
  import boot_pkg::*;

  state_t      state;
  state_t      next_state;
  boot_mode_t  mode;
  rom_width_t  width;
  logic [5:0]  sync1;
  logic [5:0]  sync2;
  logic [1:0]  samp_cnt;
  logic        h2c;
  logic        wr_pend;
  logic [7:0]  wr_ofs;
  logic [31:0] host_addr;
  logic [31:0] host_data;
  logic        rd_fill;
  logic [31:0] src;
  logic [31:0] dst;
  logic        pk_valid;
  logic [31:0] pk_word;
  logic        beat;

  // configuration pins: two-flop synchronisers
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      // default order and lane level until the pins are seen
      sync1 <= 6'h03;
      sync2 <= 6'h03;
    end
    else
    begin
      sync1 <= {rom_width_pin, boot_mode_pin, lane_correction_pin, endian_select_pin};
      sync2 <= sync1;
    end
  end

  // capture during the sample window, then frozen
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      samp_cnt             <= 2'h0;
      little_endian_select <= 1'b1;
      lane_correction      <= 1'b1;
      mode                 <= MODE_HOST;
      width                <= WIDTH_8;
    end
    else if (samp_cnt != `SAMPLE_CYCLES)
    begin
      samp_cnt             <= samp_cnt + 2'h1;
      little_endian_select <= sync2[0];
      lane_correction      <= sync2[1];
      mode                 <= boot_mode_t'(sync2[3:2]);
      width                <= rom_width_t'(sync2[5:4]);
    end
  end

  wire sample_done = (samp_cnt == `SAMPLE_CYCLES);
  wire rom_mode    = (mode == MODE_ROM);

  // bus decode
  wire        addr_ok  = hsel && hready && htrans[1];
  wire        rd_take  = addr_ok && !hwrite;
  wire        wr_take  = addr_ok && hwrite;
  wire [7:0]  ofs      = {haddr[7:2], 2'b00};
  wire        host_ok  = periph_rst_n && !rom_mode;
  wire        ctrl_wr  = wr_pend && (wr_ofs == `CTRL_OFS);
  wire        maddr_wr = wr_pend && (wr_ofs == `MADDR_OFS) && host_ok;
  wire        mdata_wr = wr_pend && (wr_ofs == `MDATA_OFS) && host_ok;
  wire        mdata_rd = rd_take && (ofs == `MDATA_OFS) && host_ok;
  wire        h2c_set  = ctrl_wr && hwdata[`CTRL_H2C_BIT] && !h2c && periph_rst_n;
  wire [31:0] status_word = {24'h00_0000, width, mode, lane_correction,
                             little_endian_select, state == ST_RUN, core_stall};
  wire [31:0] rd_mux = (ofs == `CTRL_OFS)   ? {31'h0000_0000, h2c} :
                       (ofs == `STATUS_OFS) ? status_word :
                       (ofs == `MADDR_OFS)  ? host_addr :
                       (ofs == `MDATA_OFS)  ? host_data : 32'h0000_0000;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_pend   <= 1'b0;
      wr_ofs    <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      wr_pend <= wr_take;
      wr_ofs  <= ofs;
      if (rd_take)
        hrdata <= rd_mux;
    end
  end

  // host-to-core bit: set by host or emulator, cleared by the core; set wins
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      h2c <= 1'b0;
    else if (h2c_set)
      h2c <= 1'b1;
    else if (core_int_clr)
      h2c <= 1'b0;
  end

  // host memory window with auto-increment
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      host_addr <= 32'h0000_0000;
      host_data <= 32'h0000_0000;
      rd_fill   <= 1'b0;
    end
    else
    begin
      rd_fill <= mdata_rd;
      if (maddr_wr)
        host_addr <= hwdata;
      else if (mdata_wr || mdata_rd)
        host_addr <= host_addr + 32'h0000_0004;
      if (rd_fill)
        host_data <= mem_rdata;
      else if (mdata_wr)
        host_data <= hwdata;
    end
  end

  // boot sequencing
  wire copy_end = (dst == 32'(BOOT_BYTES));
  assign beat   = (state == ST_ACK) && rom_ack;

  always_comb
  begin
    next_state = state;
    case (state)
      ST_SAMPLE: if (sample_done) next_state = rom_mode ? ST_REQ : ST_WAIT;
      ST_WAIT:   if (h2c_set) next_state = ST_RUN;
      ST_REQ:    next_state = ST_ACK;
      ST_ACK:
        if (rom_ack)
          next_state = (src + 32'h0000_0004 - (width == WIDTH_8 ? 32'h3 :
                        width == WIDTH_16 ? 32'h2 : 32'h0) == ROM_BASE + 32'(BOOT_BYTES))
                       ? ST_DRAIN : ST_REQ;
      ST_DRAIN:  if (copy_end) next_state = ST_RUN;
      ST_RUN:    next_state = ST_RUN;
      default:   next_state = ST_SAMPLE;
    endcase
  end

  wire [31:0] step = (width == WIDTH_8) ? 32'h1 : (width == WIDTH_16) ? 32'h2 : 32'h4;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state        <= ST_SAMPLE;
      core_stall   <= 1'b1;
      periph_rst_n <= 1'b0;
      core_int     <= 1'b0;
      core_start_addr <= `BOOT_ENTRY;
    end
    else
    begin
      state        <= next_state;
      periph_rst_n <= sample_done;
      core_stall   <= (next_state != ST_RUN);
      core_int     <= h2c_set && !core_stall;
      core_start_addr <= `BOOT_ENTRY;
    end
  end

  // single-frame block copy from ROM to address 0
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      src      <= ROM_BASE;
      dst      <= `BOOT_ENTRY;
      rom_req  <= 1'b0;
      rom_addr <= 32'h0000_0000;
    end
    else
    begin
      rom_req <= (next_state == ST_ACK) && !beat;
      if (state == ST_REQ)
        rom_addr <= src;
      if (beat)
        src <= src + step;
      if (pk_valid)
        dst <= dst + 32'h0000_0004;
    end
  end

  // memory port: copy engine owns it in memory boot, else the host
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mem_we    <= 1'b0;
      mem_re    <= 1'b0;
      mem_addr  <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
    end
    else
    begin
      mem_we <= pk_valid || mdata_wr;
      mem_re <= mdata_rd;
      if (pk_valid)
      begin
        mem_addr  <= dst;
        mem_wdata <= pk_word;
      end
      else if (mdata_wr || mdata_rd)
      begin
        mem_addr  <= host_addr;
        mem_wdata <= hwdata;
      end
    end
  end

  boot_packer u_packer (
    .sys_clk              (sys_clk),
    .nrst                 (nrst),
    .width                (width),
    .little_endian_select (little_endian_select),
    .lane_correction_pin  (lane_correction),
    .in_valid             (beat),
    .ext_data_lines       (ext_data_lines),
    .word_valid           (pk_valid),
    .word                 (pk_word)
  );

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  sequence host_release_s;
    (state == ST_WAIT) && h2c_set ##1 (state == ST_RUN);
  endsequence

  chk_host_release: assert property (host_release_s |-> !core_stall)
    else $error("core still stalled after host release");
  chk_rom_no_release: assert property (rom_mode && state != ST_RUN && h2c_set
    && !(state == ST_DRAIN && copy_end) |=> core_stall)
    else $error("h2c released core in memory boot");
  chk_no_pend_stall: assert property (h2c_set && core_stall |=> !core_int)
    else $error("boot-time h2c recorded as interrupt");
  chk_h2c_refuse: assert property (h2c && !core_int_clr |=> h2c && !core_int)
    else $error("h2c accepted while already set");
  chk_cfg_hold: assert property (sample_done |=> $stable(mode) && $stable(width)
    && $stable(little_endian_select) && $stable(lane_correction))
    else $error("configuration changed after sampling");
  chk_periph_rel: assert property (state == ST_SAMPLE && sample_done && !rom_mode
    |=> periph_rst_n && core_stall && state == ST_WAIT)
    else $error("peripherals not released in host boot");
  chk_copy_release: assert property ((state == ST_DRAIN) && copy_end
    |=> !core_stall && core_start_addr == 32'h0000_0000)
    else $error("core not released after copy");
  chk_copy_dest: assert property (pk_valid |=> mem_we && mem_addr < 32'(BOOT_BYTES))
    else $error("boot word outside destination block");
  chk_stall_run: assert property (state != ST_RUN |-> core_stall)
    else $error("core running before boot completes");

  // one ROM unit answered
  sequence rom_beat_s;
    (state == ST_ACK) && rom_ack;
  endsequence

  chk_rom_start: assert property (state == ST_SAMPLE && sample_done && rom_mode
    |=> state == ST_REQ && core_stall)
    else $error("memory boot did not start copying");
  chk_rom_req_hold: assert property (rom_req && !rom_ack
    |=> rom_req && $stable(rom_addr))
    else $error("ROM request dropped before its answer");
  chk_rom_step: assert property (rom_beat_s |=> src == $past(src) + step)
    else $error("ROM address did not advance by one unit");
  chk_read_fetch: assert property (mdata_rd
    |=> mem_re && mem_addr == $past(host_addr))
    else $error("host read did not fetch memory");
endmodule

// ### bench/boot_far_side.sv
// Purpose: boot ROM and device memory facing the boot block
// Assumes: same clock as the block; ack is a one-cycle pulse with data;
//          memory read data stands while the read strobe is high
// Notes: idle data lines toggle so stale values never look valid
`timescale 1ns/1ps
module boot_far_side
(
  input  wire logic        sys_clk,        // device clock
  input  wire logic        le,             // image byte order, 1 = little
  input  wire logic        lane,           // lane pin level
  input  wire logic [1:0]  width,          // rom width code
  input  wire logic        slow,           // add wait cycles per beat
  input  wire logic        rom_req,        // beat request
  input  wire logic [31:0] rom_addr,       // beat byte address
  output logic             rom_ack,        // beat done
  output logic      [31:0] ext_data_lines, // rom data lanes
  input  wire logic        mem_we,         // memory write strobe
  input  wire logic        mem_re,         // memory read strobe
  input  wire logic [31:0] mem_addr,       // memory address
  input  wire logic [31:0] mem_wdata,      // memory write data
  output logic      [31:0] mem_rdata       // read data
);
  logic [31:0] mem [0:255];
  logic [2:0]  cnt;
  logic [7:0]  b0;
  logic [7:0]  b1;
  logic [7:0]  b2;
  logic [7:0]  b3;
  logic [15:0] h;
  logic [31:0] w;
  logic        hi;
  logic [31:0] idle_rd;

  assign b0 = rom_addr[7:0] ^ 8'ha5;
  assign b1 = (rom_addr[7:0] + 8'h01) ^ 8'ha5;
  assign b2 = (rom_addr[7:0] + 8'h02) ^ 8'ha5;
  assign b3 = (rom_addr[7:0] + 8'h03) ^ 8'ha5;
  assign hi = !le && lane;
  assign h  = le ? {b1, b0} : {b0, b1};
  assign w  = le ? {b3, b2, b1, b0} : {b0, b1, b2, b3};
  assign mem_rdata = mem_re ? mem[mem_addr[9:2]] : idle_rd;

  initial
  begin
    rom_ack = 1'b0;
    ext_data_lines = 32'h0000_0000;
    idle_rd = 32'h0000_0000;
    cnt = 3'h0;
  end

  always @(posedge sys_clk)
  begin
    rom_ack <= 1'b0;
    ext_data_lines <= ~ext_data_lines;
    idle_rd <= ~idle_rd;
    if (rom_req && !rom_ack && cnt >= (slow ? 3'h3 : 3'h0))
    begin
      rom_ack <= 1'b1;
      cnt <= 3'h0;
      case (width)
        2'h0: ext_data_lines <= hi ? {b0, ~b0, ~b0, ~b0} : {~b0, ~b0, ~b0, b0};
        2'h1: ext_data_lines <= hi ? {h, ~h} : {~h, h};
        default: ext_data_lines <= w;
      endcase
    end
    else if (rom_req && !rom_ack)
      cnt <= cnt + 3'h1;
    if (mem_we)
      mem[mem_addr[9:2]] <= mem_wdata;
  end
endmodule

// ### bench/boot_and_endian_config_bench.sv
// Purpose: self-checking bench of the boot and byte-order block
// Assumes: AHB-Lite host driven here, ROM and memory in the far-side model
// Notes: boot copy shortened to 64 bytes
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin total_checks++; if ((g) !== (e)) begin \
  $display("mismatch %s expected %h seen %h", nm, e, g); n_mismatch++; end end
module boot_and_endian_config_bench;
  localparam int NB = 64;
  logic        sys_clk, nrst, endian_select_pin, lane_correction_pin, hsel, hwrite;
  logic        core_int_clr, slow;
  logic [1:0]  boot_mode_pin, rom_width_pin, htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, rd;
  wire         hreadyout, hresp, core_stall, core_int, periph_rst_n, le_out, lane_out;
  wire         rom_req, rom_ack, mem_we, mem_re;
  wire  [31:0] hrdata, core_start_addr, rom_addr, ext_data_lines, mem_addr, mem_wdata, mem_rdata;
  int          n_mismatch, total_checks, cycles, n_int;

  boot_config #(.BOOT_BYTES(NB)) dut (
    .sys_clk(sys_clk), .nrst(nrst), .endian_select_pin(endian_select_pin),
    .lane_correction_pin(lane_correction_pin), .boot_mode_pin(boot_mode_pin),
    .rom_width_pin(rom_width_pin), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .core_int_clr(core_int_clr),
    .core_stall(core_stall), .core_int(core_int), .core_start_addr(core_start_addr),
    .periph_rst_n(periph_rst_n), .little_endian_select(le_out), .lane_correction(lane_out),
    .rom_req(rom_req), .rom_addr(rom_addr), .rom_ack(rom_ack),
    .ext_data_lines(ext_data_lines), .mem_we(mem_we), .mem_re(mem_re), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  boot_far_side far (
    .sys_clk(sys_clk), .le(endian_select_pin), .lane(lane_correction_pin),
    .width(rom_width_pin), .slow(slow), .rom_req(rom_req), .rom_addr(rom_addr),
    .rom_ack(rom_ack), .ext_data_lines(ext_data_lines), .mem_we(mem_we), .mem_re(mem_re),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cycles++;
    if (core_int === 1'b1)
      n_int++;
    if (cycles == 40000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end

  function automatic logic [7:0] rb(input int a);
    return a[7:0] ^ 8'ha5;
  endfunction

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    `CHK("response", 1'b0, hresp)
  endtask

  task automatic boot(input logic [1:0] m, input logic [1:0] w, input logic e, input logic l);
    endian_select_pin <= e;
    lane_correction_pin <= l;
    boot_mode_pin <= m;
    rom_width_pin <= w;
    nrst <= 1'b0;
    repeat (8) @(posedge sys_clk);
    `CHK("stall in reset", 1'b1, core_stall)
    `CHK("periph in reset", 1'b0, periph_rst_n)
    `CHK("rom idle", 1'b0, rom_req)
    `CHK("default order", 1'b1, le_out)
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic host_run(input logic [1:0] m);
    slow <= 1'b0;
    boot(m, 2'h0, 1'b1, 1'b1);
    ahb(1'b1, 32'h8, 32'h40);
    `CHK("periph released", 1'b1, periph_rst_n)
    `CHK("core held", 1'b1, core_stall)
    ahb(1'b1, 32'hc, 32'h1234_5678);
    ahb(1'b1, 32'hc, 32'h9abc_def0);
    ahb(1'b1, 32'h8, 32'h40);
    ahb(1'b0, 32'hc, 32'h0);
    repeat (3) @(posedge sys_clk);
    ahb(1'b0, 32'hc, 32'h0);
    `CHK("readback 0", 32'h1234_5678, rd)
    repeat (3) @(posedge sys_clk);
    ahb(1'b0, 32'hc, 32'h0);
    `CHK("readback 1", 32'h9abc_def0, rd)
    `CHK("memory word", 32'h9abc_def0, far.mem[17])
    ahb(1'b0, 32'h20, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    ahb(1'b1, 32'h0, 32'h0);
    repeat (3) @(posedge sys_clk);
    `CHK("zero write", 1'b1, core_stall)
    `CHK("entry before release", 32'h0, core_start_addr)
    n_int = 0;
    ahb(1'b1, 32'h0, 32'h1);
    repeat (3) @(posedge sys_clk);
    `CHK("released", 1'b0, core_stall)
    `CHK("start address", 32'h0, core_start_addr)
    `CHK("no boot interrupt", 0, n_int)
    ahb(1'b1, 32'h0, 32'h1);
    repeat (3) @(posedge sys_clk);
    `CHK("bit still set", 0, n_int)
    core_int_clr <= 1'b1;
    @(posedge sys_clk);
    core_int_clr <= 1'b0;
    @(posedge sys_clk);
    ahb(1'b0, 32'h0, 32'h0);
    `CHK("bit cleared", 1'b0, rd[0])
    ahb(1'b1, 32'h0, 32'h1);
    repeat (3) @(posedge sys_clk);
    `CHK("interrupt taken", 1, n_int)
    $display("host boot mode %0d done", m);
  endtask

  task automatic rom_run(input int i);
    logic       e;
    logic       l;
    logic [1:0] w;
    logic [31:0] x;
    int         k;
    e = i[0];
    l = i[1];
    w = 2'(i / 4);
    slow <= i[2];
    boot(2'h2, w, e, l);
    ahb(1'b1, 32'h0, 32'h1);
    repeat (2) @(posedge sys_clk);
    `CHK("stall kept", 1'b1, core_stall)
    k = 0;
    while (core_stall === 1'b1 && k < 5000)
    begin
      @(posedge sys_clk);
      k++;
    end
    @(posedge sys_clk);
    for (int a = 0; a < NB; a += 4)
    begin
      x = e ? {rb(a + 3), rb(a + 2), rb(a + 1), rb(a)} : {rb(a), rb(a + 1), rb(a + 2), rb(a + 3)};
      `CHK("boot word", x, far.mem[a / 4])
    end
    `CHK("start address", 32'h0, core_start_addr)
    ahb(1'b0, 32'h4, 32'h0);
    `CHK("status", {w, 2'h2, l, e, 2'b10}, rd[7:0])
    endian_select_pin <= !e;
    lane_correction_pin <= !l;
    repeat (4) @(posedge sys_clk);
    `CHK("order held", e, le_out)
    `CHK("lane held", l, lane_out)
    $display("memory boot case %0d done", i);
  endtask

  initial
  begin
    nrst = 1'b0;
    endian_select_pin = 1'b1;
    lane_correction_pin = 1'b1;
    boot_mode_pin = 2'h0;
    rom_width_pin = 2'h0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    core_int_clr = 1'b0;
    slow = 1'b0;
    n_mismatch = 0;
    total_checks = 0;
    cycles = 0;
    n_int = 0;
    @(posedge sys_clk);
    for (int m = 0; m < 2; m++)
      host_run(2'(m));
    host_run(2'h3);
    for (int i = 0; i < 12; i++)
      rom_run(i);
    end_of_test();
  end
endmodule
